// ===== lcch_pkg.sv
// package of constants and types for the link configuration command handler
// Functional notes
// - bits 13-16 enable 50G, 100G, 2.5G, 5G
// - bits 17-19 enable 200G, 400G, 800G
// - bit 22 NRZ, bit 23 PAM-4
// - modulation 00 default, 01/10/11 enables
// - bit 24 Firecode, bit 25 Reed-Solomon
// - zero correction field means no correction
// - bit 28 low-power ethernet, bit 29 training
// - bit 30 enables parallel detection
// - separate 32-bit vendor settings word
// - valid set-link always answered with 0x89
// - host driver active keeps link, reason 0x0901
// - auto-negotiation ignores unsupported speed bits
// - media conflict returns reason 0x0902
// - 0x0903 contradiction, 0x0904 power level exceeded
// - phy access failure returns reason 0x0906
// - 0x0907 serdes, 0x0908 correction unsupported
// - 0x0909 eee, 0x090a training, 0x090b parallel
// - codes apply only for supported capabilities
// - valid get-link-status always answered with 0x8a
// - status response layout with status words
// - status bit 0 is link up flag
package lcch_pkg;
  localparam logic [31:0] LCCH_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] LCCH_ADDR_PARAM = 32'h0000_0004;
  localparam logic [31:0] LCCH_ADDR_VENDOR = 32'h0000_0008;
  localparam logic [31:0] LCCH_ADDR_CAPS = 32'h0000_000c;
  localparam logic [31:0] LCCH_ADDR_STATUS = 32'h0000_0010;
  localparam logic [31:0] LCCH_ADDR_RESP = 32'h0000_0014;
  localparam logic [31:0] LCCH_ADDR_APPLIED = 32'h0000_0018;
  localparam logic [31:0] LCCH_ADDR_APPVEND = 32'h0000_001c;
  localparam logic [31:0] LCCH_ADDR_LSTAT = 32'h0000_0020;
  localparam logic [31:0] LCCH_ADDR_OTHER = 32'h0000_0024;
  localparam logic [31:0] LCCH_ADDR_VSTAT = 32'h0000_0028;
  localparam logic [31:0] LCCH_ADDR_CFG = 32'h0000_002c;
  // control register fields
  localparam int LCCH_CTRL_GO = 0;
  localparam int LCCH_CTRL_GET = 1;
  localparam int LCCH_CTRL_CSUM_ERR = 2;
  localparam int LCCH_CTRL_ID_ERR = 3;
  // parameter word fields
  localparam int LCCH_P_AUTONEG = 0;
  localparam int LCCH_P_SPD_LO = 1;
  localparam int LCCH_P_SPD_HI = 7;
  localparam int LCCH_P_XSPD_LO = 13;
  localparam int LCCH_P_XSPD_HI = 19;
  localparam int LCCH_P_NRZ = 22;
  localparam int LCCH_P_PAM4 = 23;
  localparam int LCCH_P_FIRECODE = 24;
  localparam int LCCH_P_RSFEC = 25;
  localparam int LCCH_P_EEE = 28;
  localparam int LCCH_P_LT = 29;
  localparam int LCCH_P_PDET = 30;
  // reserved bits 20,21,26,27,31 are cleared before use
  localparam logic [31:0] LCCH_P_USED_MASK = 32'h73cf_ffff;
  // config register fields
  localparam int LCCH_CFG_DRV = 0;
  localparam int LCCH_CFG_MEDIA = 1;
  localparam int LCCH_CFG_PCONF = 2;
  localparam int LCCH_CFG_POWER = 3;
  localparam int LCCH_CFG_PHYERR = 4;
  localparam int LCCH_CFG_LINK = 5;
  // response and reason codes
  localparam logic [7:0] LCCH_CMD_GET = 8'h0a;
  localparam logic [7:0] LCCH_RSP_SET = 8'h89;
  localparam logic [7:0] LCCH_RSP_GET = 8'h8a;
  localparam logic [15:0] LCCH_RC_OK = 16'h0000;
  localparam logic [15:0] LCCH_RC_FAIL = 16'h0001;
  localparam logic [15:0] LCCH_RSN_NONE = 16'h0000;
  localparam logic [15:0] LCCH_RSN_DRV = 16'h0901;
  localparam logic [15:0] LCCH_RSN_MEDIA = 16'h0902;
  localparam logic [15:0] LCCH_RSN_PCONF = 16'h0903;
  localparam logic [15:0] LCCH_RSN_POWER = 16'h0904;
  localparam logic [15:0] LCCH_RSN_SPEED = 16'h0905;
  localparam logic [15:0] LCCH_RSN_PHY = 16'h0906;
  localparam logic [15:0] LCCH_RSN_SERDES = 16'h0907;
  localparam logic [15:0] LCCH_RSN_FEC = 16'h0908;
  localparam logic [15:0] LCCH_RSN_EEE = 16'h0909;
  localparam logic [15:0] LCCH_RSN_LT = 16'h090a;
  localparam logic [15:0] LCCH_RSN_PDET = 16'h090b;
  // response byte counts
  localparam logic [7:0] LCCH_SET_RSP_LEN = 8'd46;
  localparam logic [7:0] LCCH_GET_RSP_LEN = 8'd46;
  localparam logic [7:0] LCCH_SET_CSUM_OFS = 8'd20;
  localparam logic [7:0] LCCH_GET_CSUM_OFS = 8'd32;
  localparam logic [1:0] LCCH_RESP_OKAY = 2'b00;
  localparam logic [1:0] LCCH_RESP_SLVERR = 2'b10;
  localparam logic [31:0] LCCH_CAPS_RESET = 32'hffff_ffff;

  // response summary as seen by software
  typedef struct packed {
    logic [7:0] rsp_type;
    logic [7:0] csum_ofs;
    logic [15:0] reason;
  } lcch_resp_s;

  typedef enum logic [1:0] {
    LCCH_IDLE = 2'b00,
    LCCH_EVAL = 2'b01,
    LCCH_DONE = 2'b11
  } lcch_state_e;
endpackage

// ===== lcch_top.sv
// link configuration command handler with axi4-lite register access
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
module lcch_top (
  input wire logic clk_sys, // 25 mhz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [31:0] link_param_word, // applied parameter word
  output logic [31:0] vendor_link_settings_word, // applied vendor word
  output logic link_apply_pulse, // one cycle when link settings change
  output logic rsp_ready_pulse // one cycle when a response is built
);
  import lcch_pkg::*;

  lcch_state_e state_r;
  logic [31:0] param_r, vendor_r, caps_r, cfg_r;
  logic [31:0] lstat_r, other_r, vstat_r;
  logic get_r;
  logic [31:0] applied_r, appvend_r;
  lcch_resp_s resp_r;
  logic [7:0] rc_r;
  logic done_r, apply_r;
  logic [31:0] awaddr_r, wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic go_write, start;
  logic [31:0] pw;
  logic [15:0] reason_nxt;
  logic [7:0] rc_nxt;
  logic [13:0] fspd, fsup;

  // population count greater than one
  function automatic logic multi_hot(input logic [13:0] v);
    return (v & (v - 14'h0001)) != 14'h0000;
  endfunction

  // merge byte strobes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // axi write channel capture, address and data in either order
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign go_write = aw_have_r && w_have_r && !bvalid_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (go_write) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (go_write) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // write response, unmapped or read-only address answers slverr
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= LCCH_RESP_OKAY;
    end else if (go_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr_r[31:2] == LCCH_ADDR_CTRL[31:2] || awaddr_r[31:2] == LCCH_ADDR_PARAM[31:2] ||
                  awaddr_r[31:2] == LCCH_ADDR_VENDOR[31:2] || awaddr_r[31:2] == LCCH_ADDR_CAPS[31:2] ||
                  awaddr_r[31:2] == LCCH_ADDR_LSTAT[31:2] || awaddr_r[31:2] == LCCH_ADDR_OTHER[31:2] ||
                  awaddr_r[31:2] == LCCH_ADDR_VSTAT[31:2] || awaddr_r[31:2] == LCCH_ADDR_CFG[31:2])
                 ? LCCH_RESP_OKAY : LCCH_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // writable registers, command word starts the handler
  assign start = go_write && awaddr_r[31:2] == LCCH_ADDR_CTRL[31:2] && wstrb_r[0] && wdata_r[LCCH_CTRL_GO]
                 && state_r == LCCH_IDLE;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      param_r <= 32'h0000_0000;
      vendor_r <= 32'h0000_0000;
      caps_r <= LCCH_CAPS_RESET;
      cfg_r <= 32'h0000_0000;
      lstat_r <= 32'h0000_0000;
      other_r <= 32'h0000_0000;
      vstat_r <= 32'h0000_0000;
      get_r <= 1'b0;
    end else if (go_write) begin
      unique case (awaddr_r[31:2])
        LCCH_ADDR_PARAM[31:2]: param_r <= merge(param_r, wdata_r, wstrb_r);
        LCCH_ADDR_VENDOR[31:2]: vendor_r <= merge(vendor_r, wdata_r, wstrb_r);
        LCCH_ADDR_CAPS[31:2]: caps_r <= merge(caps_r, wdata_r, wstrb_r);
        LCCH_ADDR_CFG[31:2]: cfg_r <= merge(cfg_r, wdata_r, wstrb_r);
        LCCH_ADDR_LSTAT[31:2]: lstat_r <= merge(lstat_r, wdata_r, wstrb_r);
        LCCH_ADDR_OTHER[31:2]: other_r <= merge(other_r, wdata_r, wstrb_r);
        LCCH_ADDR_VSTAT[31:2]: vstat_r <= merge(vstat_r, wdata_r, wstrb_r);
        LCCH_ADDR_CTRL[31:2]: begin
          if (start) begin
            get_r <= wdata_r[LCCH_CTRL_GET];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // drop flags: a bad packet neither changes the link nor answers
  logic bad_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bad_r <= 1'b0;
    end else if (start) begin
      bad_r <= wdata_r[LCCH_CTRL_CSUM_ERR] || wdata_r[LCCH_CTRL_ID_ERR];
    end
  end

  // command sequencing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= LCCH_IDLE;
    end else begin
      unique case (state_r)
        LCCH_IDLE: if (start) state_r <= LCCH_EVAL;
        LCCH_EVAL: state_r <= LCCH_DONE;
        LCCH_DONE: state_r <= LCCH_IDLE;
        default: state_r <= LCCH_IDLE;
      endcase
    end
  end

  // reason selection for the set-link command
  assign pw = param_r & LCCH_P_USED_MASK;
  // every speed keeps its own position, so 10m and 50g never merge into one bit
  assign fspd = {pw[LCCH_P_XSPD_HI:LCCH_P_XSPD_LO], pw[LCCH_P_SPD_HI:LCCH_P_SPD_LO]};
  assign fsup = {caps_r[LCCH_P_XSPD_HI:LCCH_P_XSPD_LO], caps_r[LCCH_P_SPD_HI:LCCH_P_SPD_LO]};
  always_comb begin
    reason_nxt = LCCH_RSN_NONE;
    if (cfg_r[LCCH_CFG_DRV]) begin
      reason_nxt = LCCH_RSN_DRV;
    end else if (cfg_r[LCCH_CFG_PHYERR]) begin
      reason_nxt = LCCH_RSN_PHY;
    end else if (cfg_r[LCCH_CFG_MEDIA]) begin
      reason_nxt = LCCH_RSN_MEDIA;
    end else if (cfg_r[LCCH_CFG_PCONF]) begin
      reason_nxt = LCCH_RSN_PCONF;
    end else if (cfg_r[LCCH_CFG_POWER]) begin
      reason_nxt = LCCH_RSN_POWER;
    end else if (!pw[LCCH_P_AUTONEG] && multi_hot(fspd)) begin
      reason_nxt = LCCH_RSN_SPEED;
    end else if (!pw[LCCH_P_AUTONEG] && |(fspd & ~fsup)) begin
      reason_nxt = LCCH_RSN_PCONF;
    end else if (|(pw[LCCH_P_PAM4:LCCH_P_NRZ] & ~caps_r[LCCH_P_PAM4:LCCH_P_NRZ])) begin
      reason_nxt = LCCH_RSN_SERDES;
    end else if (|(pw[LCCH_P_RSFEC:LCCH_P_FIRECODE] & ~caps_r[LCCH_P_RSFEC:LCCH_P_FIRECODE])) begin
      reason_nxt = LCCH_RSN_FEC;
    end else if (pw[LCCH_P_EEE] && !caps_r[LCCH_P_EEE]) begin
      reason_nxt = LCCH_RSN_EEE;
    end else if (pw[LCCH_P_LT] && !caps_r[LCCH_P_LT]) begin
      reason_nxt = LCCH_RSN_LT;
    end else if (pw[LCCH_P_PDET] && !caps_r[LCCH_P_PDET]) begin
      reason_nxt = LCCH_RSN_PDET;
    end
    if (get_r) begin
      reason_nxt = cfg_r[LCCH_CFG_PHYERR] ? LCCH_RSN_PHY : LCCH_RSN_NONE;
    end
    rc_nxt = (reason_nxt == LCCH_RSN_NONE) ? LCCH_RC_OK[7:0] : LCCH_RC_FAIL[7:0];
  end

  // response build and link apply
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resp_r <= '0;
      rc_r <= 8'h00;
      applied_r <= 32'h0000_0000;
      appvend_r <= 32'h0000_0000;
      done_r <= 1'b0;
      apply_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      apply_r <= 1'b0;
      if (state_r == LCCH_EVAL && !bad_r) begin
        done_r <= 1'b1;
        rc_r <= rc_nxt;
        resp_r.reason <= reason_nxt;
        resp_r.rsp_type <= get_r ? LCCH_RSP_GET : LCCH_RSP_SET;
        resp_r.csum_ofs <= get_r ? LCCH_GET_CSUM_OFS : LCCH_SET_CSUM_OFS;
        if (!get_r && reason_nxt == LCCH_RSN_NONE) begin
          // all-zero correction field applies no correction
          applied_r <= pw;
          appvend_r <= vendor_r;
          apply_r <= 1'b1;
        end
      end
    end
  end
  assign link_param_word = applied_r;
  assign vendor_link_settings_word = appvend_r;
  assign link_apply_pulse = apply_r;
  assign rsp_ready_pulse = done_r;

  // read channel
  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= LCCH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= LCCH_RESP_OKAY;
      unique case (s_axi_araddr[31:2])
        LCCH_ADDR_CTRL[31:2]: rdata_r <= {30'h0, state_r != LCCH_IDLE, get_r};
        LCCH_ADDR_PARAM[31:2]: rdata_r <= param_r;
        LCCH_ADDR_VENDOR[31:2]: rdata_r <= vendor_r;
        LCCH_ADDR_CAPS[31:2]: rdata_r <= caps_r;
        LCCH_ADDR_STATUS[31:2]: rdata_r <= {resp_r.rsp_type, LCCH_GET_RSP_LEN, rc_r, resp_r.csum_ofs};
        LCCH_ADDR_RESP[31:2]: rdata_r <= {8'h00, rc_r, resp_r.reason};
        LCCH_ADDR_APPLIED[31:2]: rdata_r <= applied_r;
        LCCH_ADDR_APPVEND[31:2]: rdata_r <= appvend_r;
        LCCH_ADDR_LSTAT[31:2]: rdata_r <= {lstat_r[31:1], cfg_r[LCCH_CFG_LINK]};
        LCCH_ADDR_OTHER[31:2]: rdata_r <= other_r;
        LCCH_ADDR_VSTAT[31:2]: rdata_r <= vstat_r;
        LCCH_ADDR_CFG[31:2]: rdata_r <= cfg_r;
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= LCCH_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // driver conflict never touches the applied link word
  a_drv_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == LCCH_EVAL && cfg_r[LCCH_CFG_DRV] && !get_r) |=> $stable(applied_r) && !apply_r)
    else $error("link changed under driver conflict");
  a_drop_silent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == LCCH_EVAL && bad_r) |=> !done_r && !apply_r)
    else $error("bad packet answered");
  sequence s_go;
    start;
  endsequence
  sequence s_eval_ok;
    ##1 (state_r == LCCH_EVAL && !bad_r);
  endsequence
  a_resp_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_go ##0 s_eval_ok |=> done_r)
    else $error("response not built in time");
  a_set_type: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_r && !get_r |-> resp_r.rsp_type == LCCH_RSP_SET && resp_r.csum_ofs == LCCH_SET_CSUM_OFS)
    else $error("wrong set response type");
  a_get_type: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_r && get_r |-> resp_r.rsp_type == LCCH_RSP_GET && resp_r.csum_ofs == LCCH_GET_CSUM_OFS)
    else $error("wrong get response type");
  a_speed_conf: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == LCCH_EVAL && !bad_r && !get_r && cfg_r[5:0] == 6'h00 && !pw[LCCH_P_AUTONEG] && multi_hot(fspd))
    |=> resp_r.reason == LCCH_RSN_SPEED)
    else $error("forced multi speed not flagged");
  a_resv_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
    apply_r |-> (applied_r & ~LCCH_P_USED_MASK) == 32'h0000_0000)
    else $error("reserved bits applied");
  a_apply_ok: assert property (@(posedge clk_sys) disable iff (!rst_n)
    apply_r |-> done_r && resp_r.reason == LCCH_RSN_NONE && rc_r == LCCH_RC_OK[7:0])
    else $error("apply without success");
  // a status query never touches the applied link words
  a_get_noapply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_r && get_r |-> !apply_r && $stable(applied_r) && $stable(appvend_r))
    else $error("status query changed the link");
  // a status query only reports a phy access failure
  a_get_reason: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_r && get_r |-> resp_r.reason == LCCH_RSN_NONE || resp_r.reason == LCCH_RSN_PHY)
    else $error("status query with set-link reason");
  // bus answers stand until the master takes them
  a_bresp_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
endmodule

// ===== lcch_mc_model.sv
// management controller model: axi4-lite master that issues link commands
module lcch_mc_model (
  input wire logic clk_sys, // system clock
  output logic [31:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte strobes
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  output logic s_axi_bready, // write response ready
  output logic [31:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready // read data ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import lcch_pkg::*;
  // bus idle at time zero
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  // one write; handshakes judged in the low phase, acted on at the next rise
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw, w, b;
    int n;
    resp = 2'bxx;
    n = 0;
    b = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 100) begin
      @(negedge clk_sys);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b) resp = s_axi_bresp;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      n++;
    end
  endtask
  // one read, same sampling scheme as the write
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar, r;
    int n;
    d = 'x;
    resp = 2'bxx;
    n = 0;
    r = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && n < 100) begin
      @(negedge clk_sys);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      if (r) {d, resp} = {s_axi_rdata, s_axi_rresp};
      @(posedge clk_sys);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
      n++;
    end
  endtask
  // command packet: get selects status query, err marks checksum or id fault
  task automatic cmd(input logic get, input logic [1:0] err);
    logic [1:0] resp;
    wr(LCCH_ADDR_CTRL, {28'h0, err, get, 1'b1}, resp);
  endtask
endmodule

// ===== tb_link_config_command_handler.sv
// self-checking testbench for the link configuration command handler
module tb_link_config_command_handler;
  timeunit 1ns;
  timeprecision 1ns;
  import lcch_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, link_param_word, vendor_link_settings_word;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, link_apply_pulse, rsp_ready_pulse;
  int n_fail = 0;
  int check_count = 0;
  int apply_cnt = 0;
  int rsp_cnt = 0;
  logic [31:0] exp_par = 32'h0;
  logic [31:0] exp_ven = 32'h0;
  // 25 mhz clock
  always #20 clk_sys = ~clk_sys;
  lcch_top uut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_param_word,
    .vendor_link_settings_word, .link_apply_pulse, .rsp_ready_pulse);
  lcch_mc_model mc (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // pulse counters, sampled mid-cycle where outputs are settled
  always @(negedge clk_sys) begin
    if (link_apply_pulse === 1'b1) apply_cnt++;
    if (rsp_ready_pulse === 1'b1) rsp_cnt++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    mc.rd(a, d, r);
    check(d & m, exp, what);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    mc.wr(a, d, r);
    check({30'h0, r}, {30'h0, LCCH_RESP_OKAY}, "write response");
  endtask
  // one command, then count the pulses it raised over the next four clock cycles
  task automatic run_cmd(input logic get, input logic [1:0] err, input int n_rsp, input int n_app);
    int r0, a0;
    r0 = rsp_cnt;
    a0 = apply_cnt;
    mc.cmd(get, err);
    repeat (4) @(posedge clk_sys);
    check(32'(rsp_cnt - r0), 32'(n_rsp), "response pulses");
    check(32'(apply_cnt - a0), 32'(n_app), "apply pulses");
  endtask
  // set-link with given config, support mask and words; judge the outcome
  task automatic do_set(input logic [31:0] cf, cp, par, ven, input logic [15:0] rsn);
    logic ok;
    ok = (rsn === 16'h0);
    wr(LCCH_ADDR_CFG, cf);
    wr(LCCH_ADDR_CAPS, cp);
    wr(LCCH_ADDR_PARAM, par);
    wr(LCCH_ADDR_VENDOR, ven);
    run_cmd(1'b0, 2'b00, 1, ok ? 1 : 0);
    if (ok) begin
      exp_par = par & 32'h73cf_ffff;
      exp_ven = ven;
    end
    rd_chk(LCCH_ADDR_STATUS, 32'hffff_00ff, 32'h892e_0014, "set status");
    rd_chk(LCCH_ADDR_RESP, 32'hffff_ffff, {15'h0, !ok, rsn}, "set reason");
    check(link_param_word, exp_par, "applied param");
    check(vendor_link_settings_word, exp_ven, "applied vendor");
  endtask
  // reset values and refused accesses
  task automatic t_map();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(LCCH_ADDR_CAPS, 32'hffff_ffff, LCCH_CAPS_RESET, "caps reset");
    rd_chk(LCCH_ADDR_APPLIED, 32'hffff_ffff, 32'h0, "applied reset");
    mc.rd(32'h0000_0040, d, r);
    check({r, d[29:0]}, {LCCH_RESP_SLVERR, 30'h0}, "unmapped read");
    mc.wr(LCCH_ADDR_APPLIED, 32'h1234_5678, r);
    check({30'h0, r}, {30'h0, LCCH_RESP_SLVERR}, "read-only write");
    rd_chk(LCCH_ADDR_APPLIED, 32'hffff_ffff, 32'h0, "read-only kept");
    $display("test map done");
  endtask
  // success and each reason code, at least one row each
  task automatic t_set();
    logic [31:0] cf [16] = '{0, 1, 2, 4, 8, 32'h10, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    logic [31:0] cp [16] = '{'1, '1, '1, '1, '1, '1, '1, 32'hfeff_ffff, 32'hefff_ffff, 32'hdfff_ffff,
      32'hbfff_ffff, '1, 32'hff7f_ffff, 32'hffff_fffb, 32'hffff_fffb, '1};
    logic [31:0] pa [16] = '{32'hfdff_ffff, 2, 2, 2, 2, 2, 6, 32'h0100_0002, 32'h1000_0002, 32'h2000_0002,
      32'h4000_0002, 32'h0280_0004, 32'h0080_0002, 4, 5, 32'h0000_2002};
    logic [15:0] rs [16] = '{0, 16'h0901, 16'h0902, 16'h0903, 16'h0904, 16'h0906, 16'h0905, 16'h0908,
      16'h0909, 16'h090a, 16'h090b, 0, 16'h0907, 16'h0903, 0, 16'h0905};
    for (int i = 0; i < 16; i++) begin
      do_set(cf[i], cp[i], pa[i], 32'hc3a5_0000 + 32'(i), rs[i]);
    end
    $display("test set done");
  endtask
  // every modulation and correction field value is carried through
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      do_set(0, '1, 32'h0000_0003 | (32'(m) << 22) | (32'(m) << 24), 32'(m), 0);
    end
    $display("test modes done");
  endtask
  // faulted packets are dropped silently
  task automatic t_drop();
    wr(LCCH_ADDR_PARAM, 32'h0000_4001);
    run_cmd(1'b0, 2'b01, 0, 0);
    run_cmd(1'b1, 2'b10, 0, 0);
    check(link_param_word, exp_par, "dropped keeps param");
    $display("test drop done");
  endtask
  // status query with link up, phy fault and link down
  task automatic t_get();
    logic [31:0] cf [3] = '{32'h20, 32'h30, 32'h00};
    for (int i = 0; i < 3; i++) begin
      wr(LCCH_ADDR_CFG, cf[i]);
      run_cmd(1'b1, 2'b00, 1, 0);
      rd_chk(LCCH_ADDR_STATUS, 32'hff00_00ff, 32'h8a00_0020, "get status");
      rd_chk(LCCH_ADDR_RESP, 32'h0000_ffff, cf[i][4] ? 32'h0906 : 32'h0, "get reason");
      rd_chk(LCCH_ADDR_LSTAT, 32'h1, {31'h0, cf[i][5]}, "link flag");
    end
    $display("test get done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_map();
    t_set();
    t_modes();
    t_drop();
    t_get();
    stop_test();
  end
  // watchdog, far beyond the expected run length
  initial begin
    #2000000;
    n_fail++;
    stop_test();
  end
endmodule
